/* adc_regs_pkg.sv */
package adc_regs_pkg;

	// ------------------------------------------------------------
	// Register addresses and reset values
	// ------------------------------------------------------------
	localparam logic [15:0] CTRL_ADDR = 16'h0001;
	localparam logic [15:0] SCALE_ADDR = 16'h0004;
	localparam logic [15:0] THR_ADDR = 16'h0005;
	localparam logic [15:0] CTRL_RESET = 16'h0000;
	localparam logic [15:0] SCALE_RESET = 16'hA000;
	localparam logic [15:0] THR_RESET = 16'hCCCC;
	localparam logic [15:0] SCALE_UNITY = 16'h8000;

	// ------------------------------------------------------------
	// Control word bit positions
	// ------------------------------------------------------------
	localparam int CTL_FETCH_THR = 14;
	localparam int CTL_FETCH_GAIN = 13;
	localparam int CTL_FETCH_FLAG = 11;
	localparam int CTL_RESYNC = 9;
	localparam int CTL_REF_BYPASS = 7;
	localparam int CTL_SLEEP = 3;
	localparam int CTL_LOW_POWER = 2;
	localparam int CTL_REF_OFF = 1;
	localparam int CTL_DRV_OFF = 0;
	localparam logic [15:0] CTL_STORE_MASK = 16'h008B;

	// ------------------------------------------------------------
	// Flag word layout
	// ------------------------------------------------------------
	localparam int FLG_PART = 15;
	localparam int FLG_SETTLED = 10;
	localparam int FLG_OVER = 8;
	localparam int FLG_REF_ON = 4;
	localparam int FLG_DRV_ON = 3;
	localparam int FLG_LOW_POWER = 2;
	localparam logic [15:0] FLG_FIXED = 16'h4040;
	localparam logic [15:0] FLG_FIXED_MASK = 16'h7AE0;

	// Modulator samples above full scale tolerated before the fast set
	localparam logic [2:0] FAST_LIMIT = 3'h4;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} reg_write_type;

	typedef struct packed {
		logic output_valid_flag;
		logic low_power_flag;
		logic [1:0] oversample_ratio_code;
		logic stage1_valid;
		logic [15:0] stage1_mag;
		logic mod_valid;
		logic mod_full_scale;
	} datapath_status_type;

	typedef struct packed {
		logic sleep_request;
		logic ref_buffer_off;
		logic ref_bypass;
		logic input_driver_disable;
		logic resync;
	} analog_ctrl_type;

	typedef enum logic [1:0] {
		SRC_CONV = 2'h0,
		SRC_THR = 2'h1,
		SRC_GAIN = 2'h3,
		SRC_FLAG = 2'h2
	} read_source_type;

endpackage

/* adc_control_status_regs.sv */
`timescale 1ns/1ns
module adc_control_status_regs
	import adc_regs_pkg::*;
#(
	parameter logic PART_BIT = 1'b0 // Arbitrary identity value
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic wr_req,
	input wire reg_write_type wr_bus,
	input wire logic rd_req,
	input wire datapath_status_type dp,
	output analog_ctrl_type analog_q,
	output logic [15:0] scale_factor_q,
	output logic [15:0] threshold_q,
	output logic [15:0] control_view,
	output logic [15:0] flag_word,
	output logic [15:0] rd_word_q,
	output logic rd_redirect_q,
	output logic over_limit_flag
);

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------
	logic wr_ctl;
	logic wr_scale;
	logic wr_thr;
	logic [15:0] ctl_q;
	read_source_type src_q;
	read_source_type src_d;
	logic over_q;
	logic [2:0] fast_cnt_q;
	logic fast_hit;
	logic slow_hit;
	logic resync_q;

	// Address and data arrive as one framed write
	assign wr_ctl = wr_req && (wr_bus.addr == CTRL_ADDR);
	assign wr_scale = wr_req && (wr_bus.addr == SCALE_ADDR);
	assign wr_thr = wr_req && (wr_bus.addr == THR_ADDR);

	// ------------------------------------------------------------
	// Control word
	// ------------------------------------------------------------
	// Only the steady bits are stored; unused positions read zero
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			ctl_q <= CTRL_RESET;
		end else if (wr_ctl) begin
			ctl_q <= wr_bus.data & CTL_STORE_MASK;
		end
	end

	// Resync is a single-cycle strobe, never held
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			resync_q <= 1'b0;
		end else begin
			resync_q <= wr_ctl && wr_bus.data[CTL_RESYNC];
		end
	end

	// Power controls follow the stored bits; state is kept in sleep
	always_comb begin
		analog_q.sleep_request = ctl_q[CTL_SLEEP];
		analog_q.resync = resync_q;
		analog_q.ref_buffer_off = ctl_q[CTL_REF_OFF];
		analog_q.input_driver_disable = ctl_q[CTL_DRV_OFF];
		analog_q.ref_bypass = ctl_q[CTL_REF_BYPASS] && ctl_q[CTL_REF_OFF];
	end

	always_comb begin
		control_view = ctl_q;
		control_view[CTL_LOW_POWER] = dp.low_power_flag;
	end

	// ------------------------------------------------------------
	// Scale factor and threshold
	// ------------------------------------------------------------
	// Scale factor is unsigned, SCALE_UNITY meaning a gain of one
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			scale_factor_q <= SCALE_RESET;
		end else if (wr_scale) begin
			scale_factor_q <= wr_bus.data;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			threshold_q <= THR_RESET;
		end else if (wr_thr) begin
			threshold_q <= wr_bus.data;
		end
	end

	// ------------------------------------------------------------
	// Read redirect
	// ------------------------------------------------------------
	// A violating write with several bits set resolves by priority
	always_comb begin
		src_d = src_q;
		if (rd_req) begin
			src_d = SRC_CONV;
		end
		if (wr_ctl) begin
			if (wr_bus.data[CTL_FETCH_THR]) begin
				src_d = SRC_THR;
			end else if (wr_bus.data[CTL_FETCH_GAIN]) begin
				src_d = SRC_GAIN;
			end else if (wr_bus.data[CTL_FETCH_FLAG]) begin
				src_d = SRC_FLAG;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			src_q <= SRC_CONV;
		end else begin
			src_q <= src_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rd_word_q <= 16'h0000;
			rd_redirect_q <= 1'b0;
		end else if (rd_req) begin
			rd_redirect_q <= (src_q != SRC_CONV);
			unique case (src_q)
				SRC_THR: rd_word_q <= threshold_q;
				SRC_GAIN: rd_word_q <= scale_factor_q;
				SRC_FLAG: rd_word_q <= flag_word;
				SRC_CONV: rd_word_q <= 16'h0000;
			endcase
		end
	end

	// ------------------------------------------------------------
	// Flag word
	// ------------------------------------------------------------
	always_comb begin
		flag_word = FLG_FIXED;
		flag_word[FLG_PART] = PART_BIT;
		flag_word[FLG_SETTLED] = dp.output_valid_flag;
		flag_word[FLG_OVER] = over_q;
		flag_word[FLG_REF_ON] = !ctl_q[CTL_REF_OFF] && !ctl_q[CTL_SLEEP];
		flag_word[FLG_DRV_ON] = !ctl_q[CTL_DRV_OFF] && !ctl_q[CTL_SLEEP];
		flag_word[FLG_LOW_POWER] = dp.low_power_flag;
		flag_word[1:0] = dp.oversample_ratio_code;
	end

	// ------------------------------------------------------------
	// Over-limit detection
	// ------------------------------------------------------------
	// Magnitude from the first decimation stage, ahead of gain
	assign slow_hit = dp.stage1_mag > threshold_q;
	assign fast_hit = dp.mod_valid && dp.mod_full_scale && (fast_cnt_q == FAST_LIMIT);

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			fast_cnt_q <= 3'h0;
		end else if (dp.mod_valid) begin
			if (!dp.mod_full_scale) begin
				fast_cnt_q <= 3'h0;
			end else if (fast_cnt_q != FAST_LIMIT) begin
				fast_cnt_q <= fast_cnt_q + 3'h1;
			end
		end
	end

	// A fast set wins over a clearing stage one sample
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			over_q <= 1'b0;
		end else if (fast_hit) begin
			over_q <= 1'b1;
		end else if (dp.stage1_valid) begin
			over_q <= slow_hit;
		end
	end

	assign over_limit_flag = over_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	AST_READ_THR: assert property (
		rd_req && src_q == SRC_THR |=> rd_redirect_q && rd_word_q == $past(threshold_q)
	) else $error("threshold not returned on redirected read");

	AST_READ_GAIN: assert property (
		rd_req && src_q == SRC_GAIN |=> rd_redirect_q && rd_word_q == $past(scale_factor_q)
	) else $error("scale factor not returned on redirected read");

	AST_READ_FLAG: assert property (
		rd_req && src_q == SRC_FLAG |=> rd_redirect_q && rd_word_q == $past(flag_word)
	) else $error("flag word not returned on redirected read");

	AST_SELF_CLEAR: assert property (
		rd_req && !wr_ctl |=> src_q == SRC_CONV
	) else $error("redirect survived its read");

	AST_RESYNC_PULSE: assert property (
		wr_ctl && wr_bus.data[CTL_RESYNC] ##1 !wr_ctl |-> analog_q.resync ##1 !analog_q.resync
	) else $error("resync strobe wrong");

	AST_BYPASS: assert property (
		wr_ctl |=> analog_q.ref_bypass
			== ($past(wr_bus.data[CTL_REF_BYPASS]) && $past(wr_bus.data[CTL_REF_OFF]))
	) else $error("bypass while reference buffer on");

	AST_SLEEP: assert property (
		wr_ctl |=> analog_q.sleep_request == $past(wr_bus.data[CTL_SLEEP])
	) else $error("sleep request not taken from write");

	AST_FLAG_FIXED: assert property (
		(flag_word & FLG_FIXED_MASK) == FLG_FIXED && !flag_word[9]
	) else $error("fixed flag bits wrong");

	AST_OVER_SLOW: assert property (
		dp.stage1_valid && dp.stage1_mag > threshold_q |=> flag_word[FLG_OVER]
	) else $error("over-limit flag missed threshold");

	AST_OVER_FAST: assert property (
		(dp.mod_valid && dp.mod_full_scale) [*5] |=> over_limit_flag
	) else $error("fast over-limit not set");

	AST_RESET_VALUES: assert property (
		$past(rst) |-> scale_factor_q == SCALE_RESET && threshold_q == THR_RESET && ctl_q == CTRL_RESET
	) else $error("reset values wrong");

	// ------------------------------------------------------------
	// Checks on the read path
	// ------------------------------------------------------------
	AST_READ_CONV: assert property (
		rd_req && src_q == SRC_CONV |=> !rd_redirect_q && rd_word_q == 16'h0000
	) else $error("plain read returned a register");

	AST_READ_HOLD: assert property (
		!rd_req |=> rd_word_q == $past(rd_word_q)
			&& rd_redirect_q == $past(rd_redirect_q)
	) else $error("read word changed without a read");

	AST_PEND_THR: assert property (
		wr_ctl && !rd_req && wr_bus.data[CTL_FETCH_THR] |=> src_q == SRC_THR
	) else $error("threshold redirect not pending");

	AST_PEND_GAIN: assert property (
		wr_ctl && !rd_req && !wr_bus.data[CTL_FETCH_THR] && wr_bus.data[CTL_FETCH_GAIN]
			|=> src_q == SRC_GAIN
	) else $error("scale factor redirect not pending");

	AST_PEND_FLAG: assert property (
		wr_ctl && !rd_req && !wr_bus.data[CTL_FETCH_THR] && !wr_bus.data[CTL_FETCH_GAIN]
			&& wr_bus.data[CTL_FETCH_FLAG] |=> src_q == SRC_FLAG
	) else $error("flag word redirect not pending");

	AST_PEND_KEEP: assert property (
		!rd_req && !wr_ctl |=> src_q == $past(src_q)
	) else $error("pending redirect lost without a read");

	// ------------------------------------------------------------
	// Checks on the control word
	// ------------------------------------------------------------
	AST_SELF_CLEAR_BITS: assert property (
		wr_ctl |=> !control_view[CTL_FETCH_THR] && !control_view[CTL_FETCH_GAIN]
			&& !control_view[CTL_FETCH_FLAG] && !control_view[CTL_RESYNC]
	) else $error("self-clearing bit still set");

	AST_CTL_HOLD: assert property (
		!wr_ctl |=> ctl_q == $past(ctl_q)
	) else $error("control word changed without a write");

	AST_SLEEP_KEEPS_STATE: assert property (
		analog_q.sleep_request && !wr_scale && !wr_thr
			|=> scale_factor_q == $past(scale_factor_q) && threshold_q == $past(threshold_q)
	) else $error("power-down disturbed register contents");

	AST_LOW_POWER: assert property (
		control_view[CTL_LOW_POWER] == dp.low_power_flag
			&& flag_word[FLG_LOW_POWER] == dp.low_power_flag
	) else $error("low power indication wrong");

	AST_REF_OFF: assert property (
		wr_ctl |=> analog_q.ref_buffer_off == $past(wr_bus.data[CTL_REF_OFF])
	) else $error("reference buffer control not taken from write");

	AST_DRV_OFF: assert property (
		wr_ctl |=> analog_q.input_driver_disable == $past(wr_bus.data[CTL_DRV_OFF])
	) else $error("input amplifier control not taken from write");

	AST_RESYNC_CAUSE: assert property (
		analog_q.resync |-> $past(wr_ctl) && $past(wr_bus.data[CTL_RESYNC])
	) else $error("resync strobe without a write");

	AST_RESET_CTRL: assert property (
		$past(rst) |-> !control_view[CTL_SLEEP] && analog_q == '0
			&& src_q == SRC_CONV
	) else $error("control word not cleared by reset");

	// ------------------------------------------------------------
	// Checks on the flag word
	// ------------------------------------------------------------
	AST_SETTLED: assert property (
		flag_word[FLG_SETTLED] == dp.output_valid_flag
	) else $error("settled flag does not follow the datapath");

	AST_REF_IN_USE: assert property (
		flag_word[FLG_REF_ON] == !(analog_q.ref_buffer_off || analog_q.sleep_request)
	) else $error("reference in-use flag wrong");

	AST_DRV_IN_USE: assert property (
		flag_word[FLG_DRV_ON] == !(analog_q.input_driver_disable || analog_q.sleep_request)
	) else $error("amplifier in-use flag wrong");

	AST_RATE_CODE: assert property (
		flag_word[1:0] == dp.oversample_ratio_code
	) else $error("decimation code not shown");

	// ------------------------------------------------------------
	// Checks on the stored registers and over-limit
	// ------------------------------------------------------------
	AST_SCALE_WRITE: assert property (
		wr_scale |=> scale_factor_q == $past(wr_bus.data)
	) else $error("scale factor write lost");

	AST_THR_WRITE: assert property (
		wr_thr |=> threshold_q == $past(wr_bus.data)
	) else $error("threshold write lost");

	AST_OVER_CLEAR: assert property (
		dp.stage1_valid && !(dp.mod_valid && dp.mod_full_scale) && dp.stage1_mag <= threshold_q
			|=> !over_limit_flag
	) else $error("over-limit flag stuck at or below threshold");

	AST_OVER_HOLD: assert property (
		!dp.stage1_valid && !dp.mod_valid |=> over_limit_flag == $past(over_limit_flag)
	) else $error("over-limit flag changed without a sample");

	AST_FAST_RESTART: assert property (
		dp.mod_valid && !dp.mod_full_scale |=> fast_cnt_q == 3'h0
	) else $error("full-scale run count not restarted");

endmodule

/* host_model.sv */
`timescale 1ns/1ns
module host_model
	import adc_regs_pkg::*;
(
	input wire logic sys_clk,
	output logic wr_req,
	output reg_write_type wr_bus,
	output logic rd_req,
	input wire logic [15:0] rd_word_q,
	input wire logic rd_redirect_q
);
	initial begin
		wr_req = 1'b0;
		wr_bus = '0;
		rd_req = 1'b0;
	end

	// Callers set one redirect bit at most and zero in unused positions
	task automatic write_reg(input logic [15:0] addr, input logic [15:0] data);
		@(posedge sys_clk);
		wr_req <= 1'b1;
		wr_bus <= '{addr: addr, data: data};
		@(posedge sys_clk);
		wr_req <= 1'b0;
		wr_bus <= '{addr: ~addr, data: ~data};
	endtask

	task automatic read_reg(output logic [15:0] word, output logic redir);
		@(posedge sys_clk);
		rd_req <= 1'b1;
		@(posedge sys_clk);
		rd_req <= 1'b0;
		#1;
		word = rd_word_q;
		redir = rd_redirect_q;
	endtask
endmodule

/* adc_control_status_regs_tb.sv */
`timescale 1ns/1ns
module adc_control_status_regs_tb
	import adc_regs_pkg::*;
;
	logic sys_clk;
	logic rst;
	logic wr_req;
	logic rd_req;
	reg_write_type wr_bus;
	datapath_status_type dp;
	analog_ctrl_type analog_q;
	logic [15:0] scale_factor_q, threshold_q, control_view, flag_word, rd_word_q;
	logic rd_redirect_q, over_limit_flag, redir;
	logic [15:0] word;
	int fail_count = 0;
	int n_checks = 0;
	int cycles = 0;

	adc_control_status_regs uut (.sys_clk(sys_clk), .rst(rst), .wr_req(wr_req),
		.wr_bus(wr_bus), .rd_req(rd_req), .dp(dp), .analog_q(analog_q),
		.scale_factor_q(scale_factor_q), .threshold_q(threshold_q),
		.control_view(control_view), .flag_word(flag_word), .rd_word_q(rd_word_q),
		.rd_redirect_q(rd_redirect_q), .over_limit_flag(over_limit_flag));

	host_model host (.sys_clk(sys_clk), .wr_req(wr_req), .wr_bus(wr_bus),
		.rd_req(rd_req), .rd_word_q(rd_word_q), .rd_redirect_q(rd_redirect_q));

	// ------------------------------------------------------------
	// Clock, timeout and reporting
	// ------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 5000) begin
			fail_count++;
			conclude();
		end
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		check(scale_factor_q, 16'hA000);
		check(threshold_q, 16'hCCCC);
		check(control_view, 16'h0000);
		check(rd_redirect_q, 1'b0);
		$display("reset test done");
	endtask

	task automatic t_redirect();
		logic [15:0] sel [3] = '{16'h4000, 16'h2000, 16'h0800};
		logic [15:0] exp [3] = '{16'h1234, 16'h8000, 16'h4058};
		host.write_reg(16'h0005, 16'h1234);
		host.write_reg(16'h0004, 16'h8000);
		host.write_reg(16'h0002, 16'hFFFF);
		check(scale_factor_q, 16'h8000);
		check(threshold_q, 16'h1234);
		check(control_view, 16'h0000);
		for (int i = 0; i < 3; i++) begin
			host.write_reg(16'h0001, sel[i]);
			host.read_reg(word, redir);
			check(word, exp[i]);
			check(redir, 1'b1);
			host.read_reg(word, redir);
			check({redir, word[14:0]}, 16'h0000);
		end
		$display("redirect test done");
	endtask

	task automatic t_resync();
		host.write_reg(16'h0001, 16'h0200);
		#1 check(analog_q.resync, 1'b1);
		@(posedge sys_clk);
		#1 check(analog_q.resync, 1'b0);
		$display("resync test done");
	endtask

	task automatic t_power();
		logic [15:0] ctl [5] = '{16'h008B, 16'h0080, 16'h0001, 16'h0008, 16'h0000};
		logic [4:0] ana [5] = '{5'h1E, 5'h00, 5'h02, 5'h10, 5'h00};
		logic [1:0] use_flags [5] = '{2'h0, 2'h3, 2'h2, 2'h0, 2'h3};
		for (int i = 0; i < 5; i++) begin
			host.write_reg(16'h0001, ctl[i]);
			#1 check(analog_q, ana[i]);
			check(control_view, ctl[i]);
			check(flag_word[4:3], use_flags[i]);
		end
		$display("power test done");
	endtask

	task automatic t_status();
		for (int i = 0; i < 4; i++) begin
			@(posedge sys_clk);
			dp.oversample_ratio_code <= 2'(i);
			dp.low_power_flag <= i[0];
			dp.output_valid_flag <= i[1];
			@(posedge sys_clk);
			#1 check(flag_word[2:0], {i[0], i[1:0]});
			check(flag_word[10], i[1]);
			check(control_view[2], i[0]);
			check(flag_word & FLG_FIXED_MASK, FLG_FIXED);
		end
		$display("status test done");
	endtask

	task automatic stage1(input logic [15:0] mag, input logic exp);
		@(posedge sys_clk);
		dp.stage1_valid <= 1'b1;
		dp.stage1_mag <= mag;
		@(posedge sys_clk);
		dp.stage1_valid <= 1'b0;
		#1 check({flag_word[8], over_limit_flag}, {exp, exp});
	endtask

	task automatic mod_run(input int n, input logic full, input logic exp);
		repeat (n) begin
			@(posedge sys_clk);
			dp.mod_valid <= 1'b1;
			dp.mod_full_scale <= full;
		end
		@(posedge sys_clk);
		dp.mod_valid <= 1'b0;
		#1 check(over_limit_flag, exp);
	endtask

	task automatic t_over();
		stage1(16'h1235, 1'b1);
		stage1(16'h1234, 1'b0);
		mod_run(4, 1'b1, 1'b0);
		mod_run(1, 1'b0, 1'b0);
		mod_run(4, 1'b1, 1'b0);
		mod_run(1, 1'b1, 1'b1);
		stage1(16'h0000, 1'b0);
		mod_run(1, 1'b0, 1'b0);
		mod_run(5, 1'b1, 1'b1);
		$display("over limit test done");
	endtask

	task automatic t_rereset();
		host.write_reg(16'h0001, 16'h4008);
		@(posedge sys_clk);
		rst <= 1'b1;
		@(posedge sys_clk);
		rst <= 1'b0;
		#1 check(scale_factor_q, SCALE_RESET);
		check(threshold_q, THR_RESET);
		check({over_limit_flag, analog_q}, 16'h0000);
		host.read_reg(word, redir);
		check({redir, word[14:0]}, 16'h0000);
		$display("mid-run reset test done");
	endtask

	initial begin
		rst = 1'b1;
		dp = '0;
		repeat (16) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		#1 t_reset();
		t_redirect();
		t_resync();
		t_power();
		t_status();
		t_over();
		t_rereset();
		conclude();
	end
endmodule
